// >>> src/scpg_top.sv
// Clock, power gating and memory control register block
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module scpg_top
    import scpg_pkg::*;
#(
    parameter int SYSDIV_CNT_W = 7,
    parameter int AON_CNT_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_tick_i,
    input wire logic baud_osc_tick_i,
    input wire logic crystal_osc_tick_i,
    input wire logic osc_switch_done_i,
    output logic sys_clk_en_o,
    output logic aon_clk_en_o,
    output logic [2:0] selected_core_oscillator_o,
    input wire logic crystal_in_pin_i,
    output logic crystal_out_pin_o,
    output logic crystal_out_pin_oe_o,
    output logic square_wave_clk_o,
    input wire logic [2:0] pwr_state_i,
    output logic baud_osc_off_o,
    output logic primary_osc_off_o,
    output logic crystal_osc_off_o,
    input wire logic lowpower_serial_port_i,
    input wire logic lowpower_timer_a_i,
    input wire logic lowpower_timer_b_i,
    input wire logic rtc_alarm_i,
    input wire logic gpio_wake_i,
    output logic wake_o,
    output logic [1:0] op_mode_o,
    output logic div_clk_out_o,
    output logic div_clk_out_oe_o,
    output logic [31:0] periph_clk_en_o,
    output logic [31:0] periph_access_block_o,
    output logic rom_light_sleep_o,
    output logic cache_light_sleep_o,
    output logic [7:0] ram_bank_light_sleep_o,
    output logic ram_wait_state_o,
    input wire logic flash_rd_req_i,
    output logic flash_rd_ack_o
);
    scpg_reg_if rb (); // Bus to register file carrier

    logic [31:0] clkctrl; // System clock control
    logic [31:0] pm; // Power management
    logic [31:0] pclkdiv; // Divided clock and always-on divider
    logic [31:0] pclkdis0; // Peripheral clock disables
    logic [31:0] memctrl; // Memory clock control
    logic sysclk_rdy; // Clock switch complete flag
    logic switch_pending; // Select written, switch not yet done
    logic [SCPG_WAKE_N-1:0] wake_meta; // Synchroniser first stage
    logic [SCPG_WAKE_N-1:0] wake_sync; // Synchronised wake sources
    logic xtal_meta; // Crystal pin first stage
    logic [1:0] xtal_sync; // Crystal pin second stage and history
    logic crystal_bypass; // Square wave accepted on input pin
    logic [2:0] sysclk_div; // Prescaler setting
    logic [1:0] dco_ctrl; // Divided output source code
    logic dco_en; // Divided output enable
    logic dco_tick; // Tick of chosen divided output source
    logic [1:0] dco_shift; // Toggle ratio exponent
    logic dco_pulse; // Toggle request for divided output
    logic deep; // Present state is deep sleep
    logic wr_clk; // Write to system clock control
    logic wr_pm; // Write to power management
    scpg_fwstate_e fw_state; // Flash wait sequencer
    logic [2:0] fw_cnt; // Remaining flash wait cycles

    // Byte-lane merge of a write with the writable mask
    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel, input logic [31:0] wm);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return (res & wm) | (old & ~wm);
    endfunction

    // Operating mode field decode
    function automatic scpg_opmode_e mode_decode(input logic [2:0] m);
        if (m[1:0] == 2'b11) begin
            return SCPG_OPM_SHUTDOWN;
        end else if (m[2]) begin
            return SCPG_OPM_RETENTION;
        end else begin
            return SCPG_OPM_ACTIVE;
        end
    endfunction

    scpg_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .rb(rb)
    );

    assign wr_clk = rb.wr_en && (rb.addr == SCPG_OFF_CLKCTRL);
    assign wr_pm = rb.wr_en && (rb.addr == SCPG_OFF_PM);

    // Register file writes, reset values on system or power-on reset
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            clkctrl <= SCPG_RST_CLKCTRL;
            pclkdiv <= SCPG_RST_PCLKDIV;
            pclkdis0 <= SCPG_RST_PCLKDIS0;
            memctrl <= SCPG_RST_MEMCTRL;
        end else if (rb.wr_en) begin
            unique case (rb.addr)
                SCPG_OFF_CLKCTRL: begin
                    clkctrl <= wr_merge(clkctrl, rb.wdata, rb.sel, SCPG_WM_CLKCTRL);
                end
                SCPG_OFF_PCLKDIV: begin
                    pclkdiv <= wr_merge(pclkdiv, rb.wdata, rb.sel, SCPG_WM_PCLKDIV);
                end
                SCPG_OFF_PCLKDIS0: begin
                    pclkdis0 <= wr_merge(pclkdis0, rb.wdata, rb.sel, SCPG_WM_PCLKDIS0);
                end
                SCPG_OFF_MEMCTRL: begin
                    memctrl <= wr_merge(memctrl, rb.wdata, rb.sel, SCPG_WM_MEMCTRL);
                end
                default: begin
                    // Power management is written in its own block; other addresses hold nothing writable
                end
            endcase
        end
    end

    // Power management; bypass bit survives a system reset
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            pm <= SCPG_RST_PM;
        end else if (rst_i) begin
            pm <= (SCPG_RST_PM & ~SCPG_BYPASS_MASK) | (pm & SCPG_BYPASS_MASK);
        end else if (wr_pm) begin
            pm <= wr_merge(pm, rb.wdata, rb.sel, SCPG_WM_PM);
        end
    end

    // Switch ready flag; a select write beats a late done
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            sysclk_rdy <= 1'b0;
            switch_pending <= 1'b1;
        end else if (wr_clk && rb.sel[1]) begin
            sysclk_rdy <= 1'b0;
            switch_pending <= 1'b1;
        end else if (switch_pending && osc_switch_done_i) begin
            sysclk_rdy <= 1'b1;
            switch_pending <= 1'b0;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rb.rdata = 32'h0000_0000;
        unique case (rb.addr)
            SCPG_OFF_CLKCTRL: rb.rdata = clkctrl | (32'(sysclk_rdy) << SCPG_SYSRDY_BIT);
            SCPG_OFF_PM: rb.rdata = pm;
            SCPG_OFF_PCLKDIV: rb.rdata = pclkdiv;
            SCPG_OFF_PCLKDIS0: rb.rdata = pclkdis0;
            SCPG_OFF_MEMCTRL: rb.rdata = memctrl;
            default: rb.rdata = 32'h0000_0000;
        endcase
    end

    // Field extraction
    assign sysclk_div = clkctrl[SCPG_SYSDIV_LSB +: 3];
    assign selected_core_oscillator_o = clkctrl[SCPG_SYSSEL_LSB +: 3];
    assign crystal_bypass = pm[SCPG_BYPASS_BIT];
    assign dco_ctrl = pclkdiv[SCPG_DCO_CTRL_LSB +: 2];
    assign dco_en = pclkdiv[SCPG_DCO_EN_BIT];
    assign deep = (pwr_state_i == SCPG_PS_DEEP_SLEEP);

    // System clock prescaler, ratio two to the field
    scpg_clk_div #(.SEL_W(3), .CNT_W(SYSDIV_CNT_W)) u_sysdiv (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .tick_i(osc_tick_i),
        .shift_i(sysclk_div),
        .pulse_o(sys_clk_en_o)
    );

    // Always-on domain clock divider
    scpg_clk_div #(.SEL_W(2), .CNT_W(AON_CNT_W)) u_aondiv (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .tick_i(osc_tick_i),
        .shift_i(pclkdiv[SCPG_AON_LSB +: 2]),
        .pulse_o(aon_clk_en_o)
    );

    // Divided clock output source and toggle ratio
    assign dco_tick = (dco_ctrl == SCPG_DCO_BAUD2) ? baud_osc_tick_i : crystal_osc_tick_i;
    assign dco_shift = (dco_ctrl == SCPG_DCO_OFF) ? 2'h0 : dco_ctrl - 2'h1;

    scpg_clk_div #(.SEL_W(2), .CNT_W(3)) u_dcodiv (
        .clk_i(clk_i),
        .rst_i(rst_i | por_i),
        .tick_i(dco_tick),
        .shift_i(dco_shift),
        .pulse_o(dco_pulse)
    );

    // Divided output toggles, held low when off or disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            div_clk_out_o <= 1'b0;
        end else if (!dco_en || dco_ctrl == SCPG_DCO_OFF) begin
            div_clk_out_o <= 1'b0;
        end else if (dco_pulse) begin
            div_clk_out_o <= ~div_clk_out_o;
        end
    end

    assign div_clk_out_oe_o = dco_en;

    // Crystal pin synchroniser and history
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 2'b00;
        end else begin
            xtal_meta <= crystal_in_pin_i;
            xtal_sync <= {xtal_sync[0], xtal_meta};
        end
    end

    // Crystal drive when not bypassed, square wave sampled when bypassed
    assign crystal_out_pin_o = ~crystal_in_pin_i;
    assign crystal_out_pin_oe_o = ~crystal_bypass;
    assign square_wave_clk_o = crystal_bypass & xtal_sync[1];

    // Oscillator shutdown in deep sleep
    assign baud_osc_off_o = deep & pm[SCPG_BAUD_PD_BIT];
    assign primary_osc_off_o = deep & pm[SCPG_PRIM_PD_BIT];
    assign crystal_osc_off_o = deep & pm[SCPG_XTAL_PD_BIT];

    // Wake source synchronisers
    generate
        for (genvar i = 0; i < SCPG_WAKE_N; i++) begin : g_wsync
            always_ff @(posedge clk_i) begin
                if (rst_i || por_i) begin
                    wake_meta[i] <= 1'b0;
                    wake_sync[i] <= 1'b0;
                end else begin
                    wake_meta[i] <= (i == 0) ? lowpower_serial_port_i :
                                    (i == 1) ? lowpower_timer_a_i :
                                    (i == 2) ? lowpower_timer_b_i :
                                    (i == 3) ? rtc_alarm_i : gpio_wake_i;
                    wake_sync[i] <= wake_meta[i];
                end
            end
        end
    endgenerate

    // Wake request from enabled sources in the present state
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            wake_o <= 1'b0;
        end else if (pwr_state_i == SCPG_PS_ACTIVE) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= (wake_sync[3] & pm[SCPG_RTC_WE_BIT])
                    | (wake_sync[4] & pm[SCPG_GPIO_WE_BIT])
                    | ((pwr_state_i != SCPG_PS_LOW_POWER_A)
                       & ((wake_sync[0] & pm[SCPG_SER_WE_BIT])
                        | (wake_sync[1] & pm[SCPG_TMRA_WE_BIT])
                        | (wake_sync[2] & pm[SCPG_TMRB_WE_BIT])));
        end
    end

    assign op_mode_o = mode_decode(pm[SCPG_MODE_LSB +: 3]);

    // Peripheral clock gating and access blocking
    assign periph_clk_en_o = ~pclkdis0 & SCPG_PCLK_MASK;
    assign periph_access_block_o = pclkdis0 & SCPG_PCLK_MASK;

    // Memory light sleep, one RAM bit per bank pair
    assign rom_light_sleep_o = memctrl[SCPG_ROMLS_BIT];
    assign cache_light_sleep_o = memctrl[SCPG_CACHELS_BIT];
    generate
        for (genvar p = 0; p < SCPG_RAM_PAIRS; p++) begin : g_rampair
            assign ram_bank_light_sleep_o[p] = memctrl[SCPG_RAMLS_LSB + p];
            assign ram_bank_light_sleep_o[p + SCPG_RAM_PAIRS] = memctrl[SCPG_RAMLS_LSB + p];
        end
    endgenerate
    assign ram_wait_state_o = memctrl[SCPG_RAMWS_BIT];

    // Flash code read wait sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            fw_state <= SCPG_FW_IDLE;
            fw_cnt <= 3'h0;
            flash_rd_ack_o <= 1'b0;
        end else begin
            flash_rd_ack_o <= 1'b0;
            unique case (fw_state)
                SCPG_FW_IDLE: begin
                    if (flash_rd_req_i) begin
                        fw_cnt <= memctrl[SCPG_FWS_LSB +: 3];
                        fw_state <= SCPG_FW_WAIT;
                    end
                end
                SCPG_FW_WAIT: begin
                    if (fw_cnt == 3'h0) begin
                        flash_rd_ack_o <= 1'b1;
                        fw_state <= SCPG_FW_IDLE;
                    end else begin
                        fw_cnt <= fw_cnt - 3'h1;
                    end
                end
            endcase
        end
    end

    chk_bypass_keep: assert property (@(posedge clk_i)
        (rst_i && !por_i) |=> $stable(crystal_bypass)) else $error("bypass lost on reset");
    chk_xtal_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        crystal_out_pin_oe_o == !pm[SCPG_BYPASS_BIT]) else $error("crystal drive wrong");
    chk_osc_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (deep && pm[SCPG_PRIM_PD_BIT] && pm[SCPG_XTAL_PD_BIT])
        |-> (primary_osc_off_o && crystal_osc_off_o)) else $error("oscillator left on");
    chk_rdy_clear: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (wr_clk && rb.sel[1]) |=> !sysclk_rdy) else $error("ready not cleared");
    chk_flash_wait: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (fw_state == SCPG_FW_IDLE && flash_rd_req_i && memctrl[SCPG_FWS_LSB +: 3] == 3'h5)
        |=> !flash_rd_ack_o [*6] ##1 flash_rd_ack_o) else $error("flash wait count");
    chk_dco_off: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (!dco_en && !div_clk_out_oe_o) |=> !div_clk_out_o) else $error("divided out active");
    chk_mode_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (pm[1:0] == 2'b11) |-> (op_mode_o == SCPG_OPM_SHUTDOWN)) else $error("mode decode");
    chk_wake_store: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (pwr_state_i == SCPG_PS_LOW_POWER_A && !wake_sync[3] && !wake_sync[4])
        |=> !wake_o) else $error("low_power_mode_a woken by timer");
    chk_ram_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        ram_bank_light_sleep_o[7:4] == ram_bank_light_sleep_o[3:0]) else $error("pair split");
    chk_prescale: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
        (osc_tick_i && sysclk_div == 3'h0 && $stable(sysclk_div)) |=> sys_clk_en_o)
        else $error("prescaler ratio");
endmodule

// >>> src/scpg_pkg.sv
// Shared constants and types for the clock and power gating control block
package scpg_pkg;

    // Register byte offsets
    localparam logic [7:0] SCPG_OFF_CLKCTRL = 8'h08;
    localparam logic [7:0] SCPG_OFF_PM = 8'h0c;
    localparam logic [7:0] SCPG_OFF_PCLKDIV = 8'h18;
    localparam logic [7:0] SCPG_OFF_PCLKDIS0 = 8'h24;
    localparam logic [7:0] SCPG_OFF_MEMCTRL = 8'h28;

    // Reset values
    localparam logic [31:0] SCPG_RST_CLKCTRL = 32'h0000_0808;
    localparam logic [31:0] SCPG_RST_PM = 32'h0003_1000;
    localparam logic [31:0] SCPG_RST_PCLKDIV = 32'h0000_0000;
    localparam logic [31:0] SCPG_RST_PCLKDIS0 = 32'hffff_ffff;
    localparam logic [31:0] SCPG_RST_MEMCTRL = 32'h0000_0015;

    // Software-writable bits per register
    localparam logic [31:0] SCPG_WM_CLKCTRL = 32'h0000_0fc0;
    localparam logic [31:0] SCPG_WM_PM = 32'h0013_11f7;
    localparam logic [31:0] SCPG_WM_PCLKDIV = 32'h0001_c003;
    localparam logic [31:0] SCPG_WM_PCLKDIS0 = 32'h1007_a7e3;
    localparam logic [31:0] SCPG_WM_MEMCTRL = 32'h0000_3f17;

    // System clock control fields
    localparam int SCPG_SYSDIV_LSB = 6;
    localparam int SCPG_SYSSEL_LSB = 9;
    localparam int SCPG_SYSRDY_BIT = 13;
    localparam logic [31:0] SCPG_SYSSEL_MASK = 32'h0000_0e00;

    // Power management fields
    localparam int SCPG_MODE_LSB = 0;
    localparam int SCPG_GPIO_WE_BIT = 4;
    localparam int SCPG_RTC_WE_BIT = 5;
    localparam int SCPG_TMRA_WE_BIT = 6;
    localparam int SCPG_TMRB_WE_BIT = 7;
    localparam int SCPG_SER_WE_BIT = 8;
    localparam int SCPG_XTAL_PD_BIT = 12;
    localparam int SCPG_PRIM_PD_BIT = 16;
    localparam int SCPG_BAUD_PD_BIT = 17;
    localparam int SCPG_BYPASS_BIT = 20;
    localparam logic [31:0] SCPG_BYPASS_MASK = 32'h0010_0000;

    // Divided clock output and always-on divider fields
    localparam int SCPG_AON_LSB = 0;
    localparam int SCPG_DCO_CTRL_LSB = 14;
    localparam int SCPG_DCO_EN_BIT = 16;
    localparam logic [1:0] SCPG_DCO_OFF = 2'h0;
    localparam logic [1:0] SCPG_DCO_BAUD2 = 2'h1;

    // Memory control fields
    localparam int SCPG_FWS_LSB = 0;
    localparam int SCPG_RAMWS_BIT = 4;
    localparam int SCPG_RAMLS_LSB = 8;
    localparam int SCPG_CACHELS_BIT = 12;
    localparam int SCPG_ROMLS_BIT = 13;
    localparam int SCPG_RAM_PAIRS = 4;

    // Gated peripherals in the first clock-disable register
    localparam logic [31:0] SCPG_PCLK_MASK = 32'h1007_a7e3;

    // Decoded operating mode
    typedef enum logic [1:0] {
        SCPG_OPM_ACTIVE = 2'b00,
        SCPG_OPM_RETENTION = 2'b01,
        SCPG_OPM_SHUTDOWN = 2'b10
    } scpg_opmode_e;

    // Present low-power state, reported by the power sequencer
    typedef enum logic [2:0] {
        SCPG_PS_ACTIVE = 3'b000,
        SCPG_PS_SLEEP = 3'b001,
        SCPG_PS_DEEP_SLEEP = 3'b010,
        SCPG_PS_RETENTION = 3'b011,
        SCPG_PS_LOW_POWER_A = 3'b100
    } scpg_pwrstate_e;

    // Flash wait sequencer states
    typedef enum logic [0:0] {
        SCPG_FW_IDLE = 1'b0,
        SCPG_FW_WAIT = 1'b1
    } scpg_fwstate_e;

    // Number of wake sources in the synchronised vector
    localparam int SCPG_WAKE_N = 5;

endpackage

// >>> src/scpg_reg_if.sv
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface scpg_reg_if;
    logic wr_en; // One-cycle write strobe
    logic [7:0] addr; // Byte address
    logic [31:0] wdata; // Write data
    logic [3:0] sel; // Byte enables
    logic [31:0] rdata; // Read data of addressed register

    modport bus (output wr_en, output addr, output wdata, output sel, input rdata);
    modport regs (input wr_en, input addr, input wdata, input sel, output rdata);
endinterface

// >>> src/scpg_wb_slave.sv
// Classic Wishbone slave that fronts the register file
`timescale 1ns/1ps
module scpg_wb_slave
    import scpg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    scpg_reg_if.bus rb
);
    logic req; // Active request not yet answered

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rb.addr = wb_adr_i;
    assign rb.wdata = wb_dat_i;
    assign rb.sel = wb_sel_i;
    // Write lands on the edge that the master sees ack
    assign rb.wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    // Ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read data captured alongside ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            wb_dat_o <= rb.rdata;
        end
    end

    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    chk_ack_timely: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
endmodule

// >>> src/scpg_clk_div.sv
// Power-of-two enable divider counting source ticks
`timescale 1ns/1ps
module scpg_clk_div
    import scpg_pkg::*;
#(
    parameter int SEL_W = 3,
    parameter int CNT_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [SEL_W-1:0] shift_i,
    output logic pulse_o
);
    logic [CNT_W-1:0] cnt; // Tick counter
    logic [CNT_W-1:0] mask; // Low bits that must be all ones

    assign mask = ~({CNT_W{1'b1}} << shift_i);

    // Free-running tick counter; a ratio change needs no clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (tick_i) begin
            cnt <= cnt + 1'b1;
        end
    end

    // One pulse per 2**shift ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= tick_i & ((cnt & mask) == mask);
        end
    end
endmodule

// >>> sim/scpg_top_tb.sv
// Self-checking bench for the clock and power gating register block
`timescale 1ns/1ps
module scpg_top_tb
    import scpg_pkg::*;
;
    logic clk_i = 0, rst_i = 1, por_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic osc_tick_i = 0, baud_osc_tick_i = 0, crystal_osc_tick_i = 0, osc_switch_done_i = 0;
    logic crystal_in_pin_i = 0, lowpower_serial_port_i = 0, lowpower_timer_a_i = 0;
    logic lowpower_timer_b_i = 0, rtc_alarm_i = 0, gpio_wake_i = 0, flash_rd_req_i = 0;
    logic [7:0] wb_adr_i = 8'h00, ram_bank_light_sleep_o;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, q, wb_dat_o, periph_clk_en_o, periph_access_block_o;
    logic [2:0] pwr_state_i = 3'h0, selected_core_oscillator_o;
    logic wb_ack_o, crystal_out_pin_oe_o, primary_osc_off_o, crystal_osc_off_o, baud_osc_off_o;
    logic wake_o, ram_wait_state_o, flash_rd_ack_o;
    logic sys_clk_en_o, aon_clk_en_o, div_clk_out_o, div_clk_out_oe_o, square_wave_clk_o;
    logic crystal_out_pin_o, rom_light_sleep_o, cache_light_sleep_o;
    logic [1:0] op_mode_o;
    int n_errors = 0, n_compared = 0, n;
    scpg_top dut (.clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .osc_tick_i, .baud_osc_tick_i, .crystal_osc_tick_i,
        .osc_switch_done_i, .sys_clk_en_o, .aon_clk_en_o, .selected_core_oscillator_o,
        .crystal_in_pin_i, .crystal_out_pin_o, .crystal_out_pin_oe_o, .square_wave_clk_o,
        .pwr_state_i, .baud_osc_off_o, .primary_osc_off_o, .crystal_osc_off_o,
        .lowpower_serial_port_i, .lowpower_timer_a_i, .lowpower_timer_b_i, .rtc_alarm_i,
        .gpio_wake_i, .wake_o, .op_mode_o, .div_clk_out_o, .div_clk_out_oe_o,
        .periph_clk_en_o, .periph_access_block_o, .rom_light_sleep_o, .cache_light_sleep_o,
        .ram_bank_light_sleep_o, .ram_wait_state_o, .flash_rd_req_i, .flash_rd_ack_o);
    // Clock and free-running oscillator ticks
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        osc_tick_i <= ~osc_tick_i;
        baud_osc_tick_i <= ~baud_osc_tick_i;
    end
    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_compared++;
        if (s !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, s);
            n_errors++;
        end
    endtask
    // One classic bus cycle, held until ack, then a gap
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // System reset, with power-on reset when p is set
    task rst(input logic p);
        rst_i <= 1'b1;
        por_i <= p;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Reset values, unmapped offset, ready flag
    task t_regs;
        wb(0, SCPG_OFF_CLKCTRL, 0);
        chk(q, 32'h0000_0808, "clk");
        wb(0, SCPG_OFF_PM, 0);
        chk(q, 32'h0003_1000, "pm");
        wb(0, SCPG_OFF_PCLKDIS0, 0);
        chk(q, 32'hffff_ffff, "dis");
        wb(0, SCPG_OFF_MEMCTRL, 0);
        chk(q, 32'h0000_0015, "mem");
        wb(0, 8'h10, 0);
        chk(q, 0, "unmapped");
        @(posedge clk_i) osc_switch_done_i <= 1'b1;
        @(posedge clk_i) osc_switch_done_i <= 1'b0;
        wb(0, SCPG_OFF_CLKCTRL, 0);
        chk(q[13], 1, "rdy");
        wb(1, SCPG_OFF_CLKCTRL, 32'h0000_0a00);
        wb(0, SCPG_OFF_CLKCTRL, 0);
        chk(q[13], 0, "rdy clr");
        chk(selected_core_oscillator_o, 3'h5, "osc sel");
    endtask
    // Bypass kept by system reset, cleared by power-on reset
    task t_bypass;
        wb(1, SCPG_OFF_PM, 32'h0013_1000);
        chk(crystal_out_pin_oe_o, 0, "oe");
        crystal_in_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({square_wave_clk_o, crystal_out_pin_o}, 2'b10, "square");
        rst(0);
        wb(0, SCPG_OFF_PM, 0);
        chk(q[20], 1, "bp");
        rst(1);
        chk(crystal_out_pin_oe_o, 1, "oe por");
    endtask
    // Mode decode, deep-sleep power-down, alarm wake
    task t_power;
        for (int i = 0; i < 8; i++) begin
            wb(1, SCPG_OFF_PM, 32'h0003_1000 | 32'(i));
            chk(op_mode_o, (i % 4 == 3) ? 2 : (i > 3) ? 1 : 0, "mode");
        end
        pwr_state_i <= 3'h2;
        wb(0, 8'h10, 0);
        chk({primary_osc_off_o, crystal_osc_off_o, baud_osc_off_o}, 7, "pd");
        wb(1, SCPG_OFF_PM, 32'h0002_0060);
        chk({primary_osc_off_o, crystal_osc_off_o, baud_osc_off_o}, 1, "pd off");
        pwr_state_i <= 3'h4;
        lowpower_timer_a_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(wake_o, 0, "no tmr wake");
        rtc_alarm_i <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (wake_o !== 1'b1 && n < 8);
        chk(wake_o, 1, "wake");
    endtask
    // Clock gating, light sleep pairs, RAM and flash wait
    task t_mem;
        wb(1, SCPG_OFF_PCLKDIS0, 0);
        chk(periph_clk_en_o, 32'h1007_a7e3, "clk en");
        chk(periph_access_block_o, 0, "block");
        wb(1, SCPG_OFF_MEMCTRL, 32'h0000_3205);
        chk(ram_bank_light_sleep_o, 8'h22, "ram ls");
        chk({rom_light_sleep_o, cache_light_sleep_o}, 3, "rom ic ls");
        chk(ram_wait_state_o, 0, "ramws");
        @(posedge clk_i) flash_rd_req_i <= 1'b1;
        @(posedge clk_i) flash_rd_req_i <= 1'b0;
        n = 0;
        do begin @(posedge clk_i); n++; end while (flash_rd_ack_o !== 1'b1 && n < 20);
        chk(n, 7, "flash");
    endtask
    // Prescaler, always-on divider and divided output rates over 32 cycles
    task t_clk;
        logic [7:0] ns, na, nd;
        wb(1, SCPG_OFF_CLKCTRL, 32'h0000_0880);
        wb(1, SCPG_OFF_PCLKDIV, 32'h0001_4001);
        chk(div_clk_out_oe_o, 1, "dco oe");
        ns = 0;
        na = 0;
        nd = 0;
        repeat (32) begin
            @(posedge clk_i);
            ns = ns + sys_clk_en_o;
            na = na + aon_clk_en_o;
            nd = nd + div_clk_out_o;
        end
        chk(ns, 4, "sys rate");
        chk(na, 8, "aon rate");
        chk(nd, 16, "dco high");
        wb(1, SCPG_OFF_PCLKDIV, 32'h0000_0000);
        @(posedge clk_i);
        chk({div_clk_out_oe_o, div_clk_out_o}, 0, "dco off");
    endtask
    // Summary and verdict
    task stop_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        stop_test;
    end
    // Main sequence
    initial begin
        rst(1);
        t_regs;
        t_bypass;
        t_power;
        t_mem;
        t_clk;
        stop_test;
    end
endmodule
